// ===== rtl/cbcw_top.sv
// Functional notes
// - Masks 31:26, trigger 25, global mask 24, unit opcode 23:20, receive opcode 18:16.
// - Interrupt control byte and command byte are written independently.
// - A command is available as soon as it is written.
// - Acceptance may wait while DMA is busy.
// - Command byte clears on acceptance, signalling it was taken.
// - A set source mask blocks only that source's interrupt.
// - Masks: 31 done, 30 frame, 29 inactive, 28 not ready, 27 early, 26 pause.
// - Writing one to trigger raises an interrupt; zero does nothing.
// - Trigger bit always reads zero.
// - Trigger written together with global mask raises nothing.
// - Global mask set keeps the interrupt pin deasserted.
// - Global mask overrides every source mask and the trigger.
// - Opcode 0000 does nothing.
// - Opcode 0001 starts the command list at the general pointer.
// - Opcode 0010 resumes with the next block; ignored when idle.
// - Opcode 0100 latches dump address; software loads it before dumping.
// - Opcode 0101 dumps counters to the dump address.
// - Opcode 0110 loads the unit base from the general pointer.
// - Opcode 0111 dumps counters then clears them.
// - Opcode 1010 static resume, ignored when idle; software uses it when suspended.
// - Receive opcodes: start, resume, abort, load base.
// - Unit state code: 00 idle, 01 suspended, 10 low, 11 high queue; an active unit always reports 10, never 11.
`default_nettype none
module cbcw_top
  import cbcw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CBCW_ADDR_W-1:0] paddr,
  input wire logic [CBCW_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [CBCW_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cbcw_events_s events,
  input wire logic dma_busy,
  input wire logic cu_suspend_evt,
  input wire logic cu_idle_evt,
  input wire logic ru_suspend_evt,
  input wire logic ru_no_res_evt,
  input wire logic stat_dump_done,
  output cbcw_cu_req_s cu_req,
  output cbcw_ru_req_s ru_req,
  output logic [31:0] cmd_ptr,
  output logic [31:0] ru_ptr,
  output logic [31:0] cu_base,
  output logic [31:0] dump_addr,
  output logic [31:0] ru_base,
  output logic [1:0] cu_status,
  output logic [3:0] ru_status,
  output logic pci_int_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic setup;
  logic wr_en;
  logic wr_cmdw;
  logic wr_status;
  logic wr_gptr;
  logic icb_wr;
  logic cmd_wr;
  logic addr_ok;
  logic [31:0] next_rdata;

  logic [CBCW_NUM_EVT-1:0] int_mask;
  logic gmask;
  logic [3:0] cu_op;
  logic [2:0] ru_op;
  logic [31:0] gptr;
  logic [CBCW_NUM_EVT-1:0] pending;
  logic swi_pend;
  cbcw_cu_state_e cu_state;
  cbcw_ru_state_e ru_state;

  assign setup = psel & ~penable;
  // Zero wait: pready rises at the setup edge, so access takes one cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign wr_cmdw = wr_en & (paddr == CBCW_OFS_CMDW);
  assign wr_status = wr_en & (paddr == CBCW_OFS_STATUS);
  assign wr_gptr = wr_en & (paddr == CBCW_OFS_GPTR);
  assign icb_wr = wr_cmdw & pstrb[CBCW_ICB_LANE];
  assign cmd_wr = wr_cmdw & pstrb[CBCW_CMD_LANE];

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = CBCW_ZERO32;
    case (paddr)
      CBCW_OFS_CMDW: begin
        next_rdata[CBCW_MASK_HI:CBCW_MASK_LO] = int_mask;
        next_rdata[CBCW_SI_BIT] = 1'b0;
        next_rdata[CBCW_M_BIT] = gmask;
        next_rdata[CBCW_CUC_HI:CBCW_CUC_LO] = cu_op;
        next_rdata[CBCW_RUC_HI:CBCW_RUC_LO] = ru_op;
      end
      CBCW_OFS_STATUS: begin
        next_rdata[CBCW_PEND_HI:CBCW_PEND_LO] = pending;
        next_rdata[CBCW_SWI_BIT] = swi_pend;
        next_rdata[CBCW_CUS_HI:CBCW_CUS_LO] = cu_status;
        next_rdata[CBCW_RUS_HI:CBCW_RUS_LO] = ru_status;
      end
      CBCW_OFS_GPTR: next_rdata = gptr;
      CBCW_OFS_CU_BASE: next_rdata = cu_base;
      CBCW_OFS_DUMP_ADDR: next_rdata = dump_addr;
      CBCW_OFS_RU_BASE: next_rdata = ru_base;
      CBCW_OFS_CMD_PTR: next_rdata = cmd_ptr;
      CBCW_OFS_RU_PTR: next_rdata = ru_ptr;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= CBCW_ZERO32;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end else if (setup) begin
        prdata <= CBCW_ZERO32;
      end
    end
  end

  // General pointer, byte-wise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gptr <= CBCW_ZERO32;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_gptr && pstrb[i]) begin
          gptr[i*8 +: 8] <= pwdata[i*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command word bytes

  logic cmd_pend;
  logic accept;
  logic dump_wait;
  cbcw_cu_act_s cu_act;
  cbcw_ru_act_s ru_act;

  assign cmd_pend = (cu_op != CBCW_CUC_NOP) | (ru_op != CBCW_RUC_NOP);
  // A fresh write in the same cycle replaces the old command unexecuted
  assign accept = cmd_pend & ~dma_busy & ~dump_wait & ~cmd_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= '0;
      gmask <= 1'b0;
    end else if (ce && icb_wr) begin
      int_mask <= pwdata[CBCW_MASK_HI:CBCW_MASK_LO];
      gmask <= pwdata[CBCW_M_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_op <= CBCW_CUC_NOP;
      ru_op <= CBCW_RUC_NOP;
    end else if (ce) begin
      if (cmd_wr) begin
        cu_op <= pwdata[CBCW_CUC_HI:CBCW_CUC_LO];
        ru_op <= pwdata[CBCW_RUC_HI:CBCW_RUC_LO];
      end else if (accept) begin
        cu_op <= CBCW_CUC_NOP;
        ru_op <= CBCW_RUC_NOP;
      end
    end
  end

  cbcw_decode u_decode (
    .cu_op(cu_op),
    .ru_op(ru_op),
    .cu_act(cu_act),
    .ru_act(ru_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command unit

  logic cu_resume_ok;

  // Resume does nothing from idle
  assign cu_resume_ok = accept & cu_act.resume & (cu_state != CBCW_CU_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_state <= CBCW_CU_IDLE;
    end else if (ce) begin
      case (cu_state)
        CBCW_CU_IDLE: begin
          if (accept && cu_act.start) begin
            cu_state <= CBCW_CU_ACTIVE;
          end
        end
        CBCW_CU_SUSP: begin
          if (accept && (cu_act.start || cu_act.resume)) begin
            cu_state <= CBCW_CU_ACTIVE;
          end else if (cu_idle_evt) begin
            cu_state <= CBCW_CU_IDLE;
          end
        end
        CBCW_CU_ACTIVE: begin
          if (cu_idle_evt) begin
            cu_state <= CBCW_CU_IDLE;
          end else if (cu_suspend_evt) begin
            cu_state <= CBCW_CU_SUSP;
          end
        end
        default: cu_state <= CBCW_CU_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_status <= CBCW_CUS_IDLE;
    end else if (ce) begin
      case (cu_state)
        CBCW_CU_IDLE: cu_status <= CBCW_CUS_IDLE;
        CBCW_CU_SUSP: cu_status <= CBCW_CUS_SUSP;
        CBCW_CU_ACTIVE: cu_status <= CBCW_CUS_LPQ;
        default: cu_status <= CBCW_CUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ptr <= CBCW_ZERO32;
      cu_base <= CBCW_ZERO32;
      dump_addr <= CBCW_ZERO32;
    end else if (ce && accept) begin
      if (cu_act.start) begin
        cmd_ptr <= gptr;
      end
      if (cu_act.load_base) begin
        cu_base <= gptr;
      end
      if (cu_act.load_dump) begin
        dump_addr <= gptr;
      end
    end
  end

  // Clear waits for the dump to land; no command is taken meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dump_wait <= 1'b0;
    end else if (ce) begin
      if (accept && cu_act.dump_reset) begin
        dump_wait <= 1'b1;
      end else if (stat_dump_done) begin
        dump_wait <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_req <= '0;
    end else if (ce) begin
      cu_req.start <= accept & cu_act.start;
      cu_req.resume <= cu_resume_ok;
      cu_req.stat_dump <= accept & (cu_act.dump | cu_act.dump_reset);
      cu_req.stat_clear <= dump_wait & stat_dump_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive unit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ru_state <= CBCW_RU_IDLE;
    end else if (ce) begin
      case (ru_state)
        CBCW_RU_IDLE: begin
          if (accept && ru_act.start) begin
            ru_state <= CBCW_RU_READY;
          end
        end
        CBCW_RU_SUSP: begin
          if (accept && ru_act.abort) begin
            ru_state <= CBCW_RU_IDLE;
          end else if (accept && (ru_act.start || ru_act.resume)) begin
            ru_state <= CBCW_RU_READY;
          end
        end
        CBCW_RU_READY: begin
          if (accept && ru_act.abort) begin
            ru_state <= CBCW_RU_IDLE;
          end else if (ru_suspend_evt || ru_no_res_evt) begin
            ru_state <= CBCW_RU_SUSP;
          end
        end
        default: ru_state <= CBCW_RU_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ru_status <= CBCW_RUS_IDLE;
    end else if (ce) begin
      case (ru_state)
        CBCW_RU_IDLE: ru_status <= CBCW_RUS_IDLE;
        CBCW_RU_SUSP: ru_status <= CBCW_RUS_SUSP;
        CBCW_RU_READY: ru_status <= CBCW_RUS_READY;
        default: ru_status <= CBCW_RUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ru_req <= '0;
      ru_ptr <= CBCW_ZERO32;
      ru_base <= CBCW_ZERO32;
    end else if (ce) begin
      ru_req.start <= accept & ru_act.start;
      ru_req.resume <= accept & ru_act.resume & (ru_state == CBCW_RU_SUSP);
      ru_req.abort <= accept & ru_act.abort;
      if (accept && ru_act.start) begin
        ru_ptr <= gptr;
      end
      if (accept && ru_act.load_base) begin
        ru_base <= gptr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  logic [CBCW_NUM_EVT-1:0] evt_vec;
  logic swi_set;
  logic next_int;

  assign evt_vec = events;
  // Trigger alongside global mask is dropped, not deferred
  assign swi_set = icb_wr & pwdata[CBCW_SI_BIT] & ~pwdata[CBCW_M_BIT];

  for (genvar g = 0; g < CBCW_NUM_EVT; g++) begin : g_pend
    cbcw_sticky u_pend (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .set(evt_vec[g]),
      .clr(wr_status & pwdata[CBCW_PEND_LO + g]),
      .q(pending[g])
    );
  end

  cbcw_sticky u_swi (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(swi_set),
    .clr(wr_status & pwdata[CBCW_SWI_BIT]),
    .q(swi_pend)
  );

  // Global mask wins over every source and the trigger
  assign next_int = ~gmask & ((|(pending & ~int_mask)) | swi_pend);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_int_n <= 1'b1;
    end else if (ce) begin
      pci_int_n <= ~next_int;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cbcw_pkg.sv
`default_nettype none
package cbcw_pkg;

  localparam int CBCW_ADDR_W = 8;
  localparam int CBCW_DATA_W = 32;
  localparam int CBCW_NUM_EVT = 6;

  // Byte addresses on the register bus
  localparam logic [7:0] CBCW_OFS_CMDW = 8'h00;
  localparam logic [7:0] CBCW_OFS_STATUS = 8'h04;
  localparam logic [7:0] CBCW_OFS_GPTR = 8'h08;
  localparam logic [7:0] CBCW_OFS_CU_BASE = 8'h0c;
  localparam logic [7:0] CBCW_OFS_DUMP_ADDR = 8'h10;
  localparam logic [7:0] CBCW_OFS_RU_BASE = 8'h14;
  localparam logic [7:0] CBCW_OFS_CMD_PTR = 8'h18;
  localparam logic [7:0] CBCW_OFS_RU_PTR = 8'h1c;

  // Command word fields
  localparam int CBCW_MASK_HI = 31;
  localparam int CBCW_MASK_LO = 26;
  localparam int CBCW_SI_BIT = 25;
  localparam int CBCW_M_BIT = 24;
  localparam int CBCW_CUC_HI = 23;
  localparam int CBCW_CUC_LO = 20;
  localparam int CBCW_RUC_HI = 18;
  localparam int CBCW_RUC_LO = 16;
  localparam int CBCW_ICB_LANE = 3;
  localparam int CBCW_CMD_LANE = 2;

  // Status register fields
  localparam int CBCW_PEND_HI = 31;
  localparam int CBCW_PEND_LO = 26;
  localparam int CBCW_SWI_BIT = 25;
  localparam int CBCW_CUS_HI = 7;
  localparam int CBCW_CUS_LO = 6;
  localparam int CBCW_RUS_HI = 5;
  localparam int CBCW_RUS_LO = 2;

  localparam logic [3:0] CBCW_CUC_NOP = 4'h0;
  localparam logic [3:0] CBCW_CUC_START = 4'h1;
  localparam logic [3:0] CBCW_CUC_RESUME = 4'h2;
  localparam logic [3:0] CBCW_CUC_LOAD_DUMP = 4'h4;
  localparam logic [3:0] CBCW_CUC_DUMP = 4'h5;
  localparam logic [3:0] CBCW_CUC_LOAD_BASE = 4'h6;
  localparam logic [3:0] CBCW_CUC_DUMP_RESET = 4'h7;
  localparam logic [3:0] CBCW_CUC_STATIC_RESUME = 4'ha;

  localparam logic [2:0] CBCW_RUC_NOP = 3'h0;
  localparam logic [2:0] CBCW_RUC_START = 3'h1;
  localparam logic [2:0] CBCW_RUC_RESUME = 3'h2;
  localparam logic [2:0] CBCW_RUC_ABORT = 3'h4;
  localparam logic [2:0] CBCW_RUC_LOAD_BASE = 3'h6;

  localparam logic [1:0] CBCW_CUS_IDLE = 2'h0;
  localparam logic [1:0] CBCW_CUS_SUSP = 2'h1;
  localparam logic [1:0] CBCW_CUS_LPQ = 2'h2;
  localparam logic [1:0] CBCW_CUS_HPQ = 2'h3;

  localparam logic [3:0] CBCW_RUS_IDLE = 4'h0;
  localparam logic [3:0] CBCW_RUS_SUSP = 4'h1;
  localparam logic [3:0] CBCW_RUS_NORES = 4'h2;
  localparam logic [3:0] CBCW_RUS_READY = 4'h4;

  localparam logic [31:0] CBCW_ZERO32 = 32'h0000_0000;

  typedef enum logic [2:0] {
    CBCW_CU_IDLE = 3'b001,
    CBCW_CU_SUSP = 3'b010,
    CBCW_CU_ACTIVE = 3'b100
  } cbcw_cu_state_e;

  typedef enum logic [2:0] {
    CBCW_RU_IDLE = 3'b001,
    CBCW_RU_SUSP = 3'b010,
    CBCW_RU_READY = 3'b100
  } cbcw_ru_state_e;

  // Bit order matches mask bits 31 down to 26
  typedef struct packed {
    logic command_done_event;
    logic frame_received_event;
    logic command_unit_inactive_event;
    logic receiver_not_ready_event;
    logic early_receive_event;
    logic flow_pause_event;
  } cbcw_events_s;

  typedef struct packed {
    logic start;
    logic resume;
    logic load_dump;
    logic dump;
    logic load_base;
    logic dump_reset;
  } cbcw_cu_act_s;

  typedef struct packed {
    logic start;
    logic resume;
    logic abort;
    logic load_base;
  } cbcw_ru_act_s;

  typedef struct packed {
    logic start;
    logic resume;
    logic stat_dump;
    logic stat_clear;
  } cbcw_cu_req_s;

  typedef struct packed {
    logic start;
    logic resume;
    logic abort;
  } cbcw_ru_req_s;

endpackage
`default_nettype wire

// ===== rtl/cbcw_sticky.sv
`default_nettype none
module cbcw_sticky
  import cbcw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cbcw_decode.sv
`default_nettype none
module cbcw_decode
  import cbcw_pkg::*;
(
  input wire logic [3:0] cu_op,
  input wire logic [2:0] ru_op,
  output cbcw_cu_act_s cu_act,
  output cbcw_ru_act_s ru_act
);

  always_comb begin
    cu_act = '0;
    case (cu_op)
      CBCW_CUC_NOP: cu_act = '0;
      CBCW_CUC_START: cu_act.start = 1'b1;
      CBCW_CUC_RESUME: cu_act.resume = 1'b1;
      CBCW_CUC_STATIC_RESUME: cu_act.resume = 1'b1;
      CBCW_CUC_LOAD_DUMP: cu_act.load_dump = 1'b1;
      CBCW_CUC_DUMP: cu_act.dump = 1'b1;
      CBCW_CUC_LOAD_BASE: cu_act.load_base = 1'b1;
      CBCW_CUC_DUMP_RESET: cu_act.dump_reset = 1'b1;
      default: cu_act = '0;
    endcase
  end

  always_comb begin
    ru_act = '0;
    case (ru_op)
      CBCW_RUC_START: ru_act.start = 1'b1;
      CBCW_RUC_RESUME: ru_act.resume = 1'b1;
      CBCW_RUC_ABORT: ru_act.abort = 1'b1;
      CBCW_RUC_LOAD_BASE: ru_act.load_base = 1'b1;
      default: ru_act = '0;
    endcase
  end

endmodule
`default_nettype wire

// ===== tb/cbcw_dp_model.sv
`default_nettype none
module cbcw_dp_model
  import cbcw_pkg::*;
#(
  parameter int DLY = 3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire cbcw_cu_req_s cu_req,
  output logic stat_dump_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Counter dump takes a few cycles, never instant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      stat_dump_done <= 1'b0;
    end else begin
      stat_dump_done <= (cnt == 1);
      if (cu_req.stat_dump) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cbcw_chk_sva.sv
`default_nettype none
module cbcw_chk
  import cbcw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CBCW_ADDR_W-1:0] paddr,
  input wire logic [CBCW_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [CBCW_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma_busy,
  input wire logic stat_dump_done,
  input wire cbcw_cu_req_s cu_req,
  input wire logic [1:0] cu_status,
  input wire logic pci_int_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence s_acc;
    psel && penable && pready && pwrite && paddr == CBCW_OFS_CMDW;
  endsequence
  sequence s_icb_wr;
    s_acc ##0 pstrb[3];
  endsequence
  // Start write, then a free DMA cycle
  sequence s_start;
    s_acc ##0 (pstrb[2] && pwdata[23:20] == CBCW_CUC_START) ##1 !dma_busy;
  endsequence
  ////////////////////////////////////////
  AST_PREADY_ACC: assert property (psel && !penable |=> pready)
    else $error("pready missing in access phase");
  AST_UNMAPPED: assert property (pready && paddr > CBCW_OFS_RU_PTR |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
  AST_SI_READS_ZERO: assert property (pready && !pwrite && paddr == CBCW_OFS_CMDW |-> !prdata[CBCW_SI_BIT])
    else $error("trigger bit read as one");
  AST_SI_RAISES: assert property (s_icb_wr ##0 (pwdata[25] && !pwdata[24]) |=> ##1 !pci_int_n)
    else $error("trigger did not raise interrupt");
  AST_M_BLOCKS: assert property (s_icb_wr ##0 pwdata[24] |=> ##1 pci_int_n [*2])
    else $error("interrupt asserted under global mask");
  AST_START_LAT: assert property (s_start |=> cu_req.start)
    else $error("start not accepted in time");
  AST_DMA_HOLD: assert property (cu_req.start || cu_req.resume || cu_req.stat_dump |-> !$past(dma_busy))
    else $error("command accepted while dma busy");
  AST_DUMP_CLEAR: assert property (cu_req.stat_clear |-> $past(stat_dump_done))
    else $error("clear before dump finished");
  AST_START_STATE: assert property (cu_req.start |=> cu_status == CBCW_CUS_LPQ)
    else $error("unit not active after start");
  AST_DUMP_PULSE: assert property ($rose(cu_req.stat_dump) |=> !cu_req.stat_dump ##1 !cu_req.stat_clear)
    else $error("dump request not a single pulse");
endmodule
bind cbcw_top cbcw_chk u_chk (.*);
`default_nettype wire

// ===== tb/cbcw_top_tb.sv
`default_nettype none
module cbcw_top_tb;
  import cbcw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] GP = 32'h1234_5678;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic dma_busy = 1'b0;
  logic cu_sus = 1'b0;
  logic ru_sus = 1'b0;
  cbcw_events_s events = '0;
  logic [31:0] prdata, cmd_ptr, ru_ptr, cu_base, dump_addr, ru_base, rd;
  logic pready, pslverr, pci_int_n, stat_dump_done, perr;
  cbcw_cu_req_s cu_req;
  cbcw_ru_req_s ru_req;
  logic [1:0] cu_status;
  logic [3:0] ru_status;
  int errors = 0, compares = 0, cyc = 0, n_st = 0, n_rs = 0, n_dp = 0, n_cl = 0, n_ab = 0, n_ru = 0, n_rr = 0;

  // Idle and no-resource events unused here, tied quiet
  cbcw_top dut (.*, .ce(1'b1), .cu_suspend_evt(cu_sus), .cu_idle_evt(1'b0), .ru_suspend_evt(ru_sus),
    .ru_no_res_evt(1'b0));
  cbcw_dp_model #(.DLY(3)) u_dp (.pclk(pclk), .presetn(presetn), .cu_req(cu_req),
    .stat_dump_done(stat_dump_done));

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n_st <= n_st + int'(cu_req.start);
    n_rs <= n_rs + int'(cu_req.resume);
    n_dp <= n_dp + int'(cu_req.stat_dump);
    n_cl <= n_cl + int'(cu_req.stat_clear);
    n_ab <= n_ab + int'(ru_req.abort);
    n_ru <= n_ru + int'(ru_req.start);
    n_rr <= n_rr + int'(ru_req.resume);
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave latency not assumed; global timeout covers a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, CBCW_OFS_CMDW, c, 4'b0100);
    wt(3);
    apb(1'b0, CBCW_OFS_CMDW, 32'h0, 4'h0);
    chk("cmd_byte", 32'h0, rd);
  endtask
  task automatic evt(input int i);
    @(posedge pclk);
    events <= cbcw_events_s'(6'(1 << i));
    @(posedge pclk);
    events <= '0;
    wt(2);
  endtask
  task automatic sus();
    @(posedge pclk);
    cu_sus <= 1'b1;
    @(posedge pclk);
    cu_sus <= 1'b0;
    wt(2);
    chk("cu_status", 32'h1, 32'(cu_status));
  endtask
  ////////////////////////////////////////
  initial begin
    wt(2);
    presetn <= 1'b1;
    chk("int_n", 32'h1, 32'(pci_int_n));
    apb(1'b0, CBCW_OFS_CMDW, 32'h0, 4'h0);
    chk("cmdw", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk("slverr", 32'h1, 32'(perr));
    apb(1'b1, CBCW_OFS_CMDW, 32'hfcff_ffff, 4'b1000);
    apb(1'b1, CBCW_OFS_CMDW, 32'h0, 4'b0100);
    apb(1'b0, CBCW_OFS_CMDW, 32'h0, 4'h0);
    chk("cmdw", 32'hfc00_0000, rd);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CBCW_OFS_CMDW, 32'h1 << (26 + i), 4'b1000);
      evt(i);
      chk("int_n", 32'h1, 32'(pci_int_n));
      apb(1'b0, CBCW_OFS_STATUS, 32'h0, 4'h0);
      chk("status", 32'h1 << (26 + i), rd);
      apb(1'b1, CBCW_OFS_STATUS, 32'hfc00_0000, 4'hf);
      evt((i + 1) % 6);
      chk("int_n", 32'h0, 32'(pci_int_n));
      apb(1'b1, CBCW_OFS_STATUS, 32'hfc00_0000, 4'hf);
      wt(2);
      chk("int_n", 32'h1, 32'(pci_int_n));
    end
    apb(1'b1, CBCW_OFS_CMDW, 32'h0100_0000, 4'b1000);
    evt(0);
    chk("int_n", 32'h1, 32'(pci_int_n));
    apb(1'b1, CBCW_OFS_CMDW, 32'h0, 4'b1000);
    wt(2);
    chk("int_n", 32'h0, 32'(pci_int_n));
    apb(1'b1, CBCW_OFS_STATUS, 32'hfc00_0000, 4'hf);
    apb(1'b1, CBCW_OFS_CMDW, 32'h0200_0000, 4'b1000);
    wt(2);
    chk("int_n", 32'h0, 32'(pci_int_n));
    apb(1'b0, CBCW_OFS_CMDW, 32'h0, 4'h0);
    chk("cmdw", 32'h0, rd);
    apb(1'b1, CBCW_OFS_STATUS, 32'h0200_0000, 4'hf);
    apb(1'b1, CBCW_OFS_CMDW, 32'h0300_0000, 4'b1000);
    wt(2);
    chk("int_n", 32'h1, 32'(pci_int_n));
    apb(1'b1, CBCW_OFS_CMDW, 32'h0, 4'b1000);
    wt(2);
    chk("int_n", 32'h1, 32'(pci_int_n));
    apb(1'b1, CBCW_OFS_GPTR, GP, 4'hf);
    cmd(32'h0020_0000);
    cmd(32'h00a0_0000);
    chk("resumes", 32'h0, n_rs);
    cmd(32'h00f0_0000);
    cmd(32'h0000_0000);
    chk("cu_status", 32'h0, 32'(cu_status));
    cmd(32'h0060_0000);
    chk("cu_base", GP, cu_base);
    cmd(32'h0040_0000);
    chk("dump_addr", GP, dump_addr);
    cmd(32'h0006_0000);
    chk("ru_base", GP, ru_base);
    cmd(32'h0001_0000);
    chk("ru_ptr", GP, ru_ptr);
    chk("ru_status", 32'h4, 32'(ru_status));
    chk("ru_starts", 32'h1, n_ru);
    @(posedge pclk);
    ru_sus <= 1'b1;
    @(posedge pclk);
    ru_sus <= 1'b0;
    wt(2);
    chk("ru_status", 32'h1, 32'(ru_status));
    cmd(32'h0002_0000);
    chk("ru_resumes", 32'h1, n_rr);
    chk("ru_status", 32'h4, 32'(ru_status));
    cmd(32'h0004_0000);
    chk("aborts", 32'h1, n_ab);
    dma_busy <= 1'b1;
    apb(1'b1, CBCW_OFS_CMDW, 32'h0010_0000, 4'b0100);
    wt(4);
    apb(1'b0, CBCW_OFS_CMDW, 32'h0, 4'h0);
    chk("cmdw", 32'h0010_0000, rd);
    dma_busy <= 1'b0;
    cmd(32'h0);
    chk("cmd_ptr", GP, cmd_ptr);
    chk("cu_status", 32'h2, 32'(cu_status));
    sus();
    cmd(32'h0020_0000);
    chk("resumes", 32'h1, n_rs);
    sus();
    cmd(32'h00a0_0000);
    chk("resumes", 32'h2, n_rs);
    sus();
    cmd(32'h0010_0000);
    chk("starts", 32'h2, n_st);
    cmd(32'h0050_0000);
    wt(6);
    chk("dumps", 32'h1, n_dp);
    cmd(32'h0070_0000);
    wt(8);
    chk("dumps", 32'h2, n_dp);
    chk("clears", 32'h1, n_cl);
    print_verdict();
  end
endmodule
`default_nettype wire
